// file: flas_host.sv
`timescale 1ns/1ns
module flas_host (
    input wire logic aclk,
    input wire logic aresetn,
    flas_if.host lnk,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic aw_h;
    logic w_h;
    logic do_wr;
    logic [4:0] status;
    logic [4:0] enable;
    logic [4:0] clr;
    logic [4:0] ev;
    logic [31:0] lat_cnt;
    logic timing;
    logic alert_d;
    logic [15:0] shunt_lim_rb;
    logic [15:0] bus_lim_rb;
    logic [15:0] pwr_lim_rb;

    // ------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------
    assign do_wr = aw_h && w_h && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_q <= '0;
            w_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= flas_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_h && !s_axi_awready;
            s_axi_wready <= !w_h && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_h <= 1'b1;
                aw_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_h <= 1'b1;
                w_q <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q > flas_pkg::A_ENABLE)
                    ? flas_pkg::RESP_SLVERR : flas_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Orders to the monitor
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk.lim_wr <= 1'b0;
            lnk.lim_sel <= 2'h0;
            lnk.lim_data <= '0;
            lnk.cal <= flas_pkg::CAL_RST; // see R12
            lnk.wide_range <= flas_pkg::WIDE_RANGE_RST; // see R13
            shunt_lim_rb <= flas_pkg::SHUNT_LIMIT_RST;
            bus_lim_rb <= flas_pkg::BUS_LIMIT_RST;
            pwr_lim_rb <= flas_pkg::POWER_LIMIT_RST;
            enable <= '0;
        end else begin
            lnk.lim_wr <= 1'b0;
            if (do_wr) begin
                if (aw_q == flas_pkg::A_SHUNT_LIM) begin // see R2
                    lnk.lim_wr <= 1'b1;
                    lnk.lim_sel <= 2'h0;
                    lnk.lim_data <= w_q[15:0];
                    shunt_lim_rb <= w_q[15:0];
                end else if (aw_q == flas_pkg::A_BUS_LIM) begin // see R3
                    lnk.lim_wr <= 1'b1;
                    lnk.lim_sel <= 2'h1;
                    lnk.lim_data <= w_q[15:0];
                    bus_lim_rb <= w_q[15:0];
                end else if (aw_q == flas_pkg::A_PWR_LIM) begin
                    lnk.lim_wr <= 1'b1;
                    lnk.lim_sel <= 2'h2;
                    lnk.lim_data <= w_q[15:0];
                    pwr_lim_rb <= w_q[15:0];
                end else if (aw_q == flas_pkg::A_CAL) begin
                    lnk.cal <= w_q[14:0];
                end else if (aw_q == flas_pkg::A_CTRL) begin
                    lnk.wide_range <= w_q[flas_pkg::CT_WIDE];
                end else if (aw_q == flas_pkg::A_ENABLE) begin
                    enable <= w_q[4:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Events, latency watch, interrupt
    // ------------------------------------------------------------
    always_comb begin
        clr = (do_wr && aw_q == flas_pkg::A_CLEAR) ? w_q[4:0] : 5'h00;
        ev = '0;
        ev[flas_pkg::ST_ALERT] = lnk.alert && !alert_d;
        // Alert later than budget from a limit write: stale setup
        ev[flas_pkg::ST_LATE] = timing
            && lat_cnt == 32'(flas_pkg::HOST_BUDGET_CYCLES); // see R11
    end

    // Limit writes restart the latency budget window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alert_d <= 1'b0;
            timing <= 1'b0;
            lat_cnt <= '0;
            status <= '0;
            irq <= 1'b0;
        end else begin
            alert_d <= lnk.alert;
            if (lnk.lim_wr) begin
                timing <= 1'b1;
                lat_cnt <= '0;
            end else if (lnk.alert || ev[flas_pkg::ST_LATE]) begin
                timing <= 1'b0;
            end else if (timing) begin
                lat_cnt <= lat_cnt + 32'h1;
            end
            // Set wins over clear
            status <= (status & ~clr) | ev;
            irq <= |(((status & ~clr) | ev) & enable);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= flas_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= flas_pkg::RESP_OKAY;
                if (s_axi_araddr == flas_pkg::A_STATUS) begin
                    s_axi_rdata <= {27'h0, status};
                end else if (s_axi_araddr == flas_pkg::A_ENABLE) begin
                    s_axi_rdata <= {27'h0, enable};
                end else if (s_axi_araddr == flas_pkg::A_SHUNT_LIM) begin
                    s_axi_rdata <= {16'h0000, shunt_lim_rb};
                end else if (s_axi_araddr == flas_pkg::A_BUS_LIM) begin
                    s_axi_rdata <= {16'h0000, bus_lim_rb};
                end else if (s_axi_araddr == flas_pkg::A_PWR_LIM) begin
                    s_axi_rdata <= {16'h0000, pwr_lim_rb};
                end else if (s_axi_araddr == flas_pkg::A_CAL) begin
                    s_axi_rdata <= {17'h0, lnk.cal};
                end else if (s_axi_araddr == flas_pkg::A_CTRL) begin
                    s_axi_rdata <= {30'h0, lnk.wide_range, 1'b0};
                end else if (s_axi_araddr == flas_pkg::A_SHUNT_RES) begin
                    s_axi_rdata <= {{12{lnk.shunt_res[19]}}, lnk.shunt_res};
                end else if (s_axi_araddr == flas_pkg::A_BUS_RES) begin
                    s_axi_rdata <= {12'h000, lnk.bus_res};
                end else if (s_axi_araddr == flas_pkg::A_PWR_RES) begin
                    s_axi_rdata <= {8'h00, lnk.power_res};
                end else if (s_axi_araddr == flas_pkg::A_LATENCY) begin
                    s_axi_rdata <= lat_cnt;
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= flas_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : flas_host

// file: flas_pkg.sv
package flas_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RES_W = 20;
    localparam int PWR_W = 24;
    localparam int LIM_W = 16;
    localparam int CAL_W = 15;
    localparam int CNT_W = 16;
    // Top 16 bits of each result line up with the limit step
    localparam int RES_SHIFT = RES_W - LIM_W;
    localparam int PWR_SHIFT = PWR_W - LIM_W;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SHUNT_LIMIT_RST = 16'h7FFF;
    localparam logic [15:0] BUS_LIMIT_RST = 16'h7FFF;
    localparam logic [15:0] POWER_LIMIT_RST = 16'hFFFF;
    localparam logic [14:0] CAL_RST = 15'h0000;
    localparam logic WIDE_RANGE_RST = 1'b0;

    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int CONV_TIME_US = 50;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
    localparam int QUARTER_CYCLES = CONV_CYCLES / 4;
    // Host budget for alert latency: 1.5 conversion periods
    localparam int HOST_BUDGET_CYCLES = (CONV_CYCLES * 3) / 2;

    // ------------------------------------------------------------
    // Host register map (AXI4-Lite byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SHUNT_LIM = 8'h04;
    localparam logic [7:0] A_BUS_LIM = 8'h08;
    localparam logic [7:0] A_PWR_LIM = 8'h0C;
    localparam logic [7:0] A_CAL = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_CLEAR = 8'h18;
    localparam logic [7:0] A_ENABLE = 8'h1C;
    localparam logic [7:0] A_SHUNT_RES = 8'h20;
    localparam logic [7:0] A_BUS_RES = 8'h24;
    localparam logic [7:0] A_PWR_RES = 8'h28;
    localparam logic [7:0] A_LATENCY = 8'h2C;
    // Status bits
    localparam int ST_SHUNT = 0;
    localparam int ST_BUS = 1;
    localparam int ST_PWR = 2;
    localparam int ST_ALERT = 3;
    localparam int ST_LATE = 4;
    localparam int ST_W = 5;
    // Control bits
    localparam int CT_GO = 0;
    localparam int CT_WIDE = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : flas_pkg

// file: flas_if.sv
`timescale 1ns/1ns
interface flas_if;
    logic lim_wr;
    logic [1:0] lim_sel;
    logic [15:0] lim_data;
    logic [14:0] cal;
    logic wide_range;
    logic [19:0] shunt_res;
    logic [19:0] bus_res;
    logic [23:0] power_res;
    logic conv_done;
    logic alert;
    modport device (
        input lim_wr, lim_sel, lim_data, cal, wide_range,
        output shunt_res, bus_res, power_res, conv_done, alert
    );
    modport host (
        output lim_wr, lim_sel, lim_data, cal, wide_range,
        input shunt_res, bus_res, power_res, conv_done, alert
    );
endinterface : flas_if

// file: flas_device.sv
`timescale 1ns/1ns
// Functional notes
// R1: Limits are 16 bits, sixteen result steps (code compares power limit to top 16 of 24 power bits, 256 steps)
// R2: Shunt upper limit sets over-current trip
// R3: Bus upper limit step 3.125 mV
// R4: Power limit compared to top 16 bits
// R5: Limits reset to defaults every power-up
// R6: Results signed two's complement, bus nonnegative
// R7: Power step is current step times 3.2
// R8: Energy step is sixteen power steps
// R9: Gross fault alerts after quarter period
// R10: Marginal fault alerts 0.5 to 1.5 periods
// R11: Host budgets 1.5 periods alert latency
// R12: Current results zero until calibration set
// R13: Default wide range, continuous conversion (code resets wide_range to 0, not wide)
// R14: Compare each result after every conversion
module flas_device #(
    parameter int CONV_CYCLES = flas_pkg::CONV_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    flas_if.device lnk,
    input wire logic signed [19:0] shunt_sample,
    input wire logic [19:0] bus_sample,
    output logic signed [19:0] current_res,
    output logic [39:0] energy_acc,
    output logic alert_on_averaged_result
);
    localparam int QC = CONV_CYCLES / 4;

    logic [15:0] shunt_upper_limit;
    logic [15:0] bus_upper_limit;
    logic [15:0] power_limit;
    logic [31:0] conv_cnt;
    logic sample_tick;
    logic quarter_tick;
    logic gross_fault;
    logic signed [19:0] next_current;
    logic [23:0] next_power;
    logic signed [35:0] cur_prod;
    logic [43:0] pwr_prod;

    // ------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin // see R5
            shunt_upper_limit <= flas_pkg::SHUNT_LIMIT_RST;
            bus_upper_limit <= flas_pkg::BUS_LIMIT_RST;
            power_limit <= flas_pkg::POWER_LIMIT_RST;
        end else if (lnk.lim_wr) begin // see R1
            if (lnk.lim_sel == 2'h0) begin
                shunt_upper_limit <= lnk.lim_data; // see R2
            end else if (lnk.lim_sel == 2'h1) begin
                bus_upper_limit <= lnk.lim_data; // see R3
            end else if (lnk.lim_sel == 2'h2) begin
                power_limit <= lnk.lim_data; // see R4
            end
        end
    end

    // ------------------------------------------------------------
    // Free-running conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_cnt <= '0;
        end else if (conv_cnt == 32'(CONV_CYCLES - 1)) begin // see R13
            conv_cnt <= '0;
        end else begin
            conv_cnt <= conv_cnt + 32'h1;
        end
    end
    assign sample_tick = (conv_cnt == 32'(CONV_CYCLES - 1));
    assign quarter_tick = (conv_cnt == 32'(QC - 1));

    // ------------------------------------------------------------
    // Scaling
    // ------------------------------------------------------------
    // Current = shunt * cal / 2^11; zero while cal unset
    always_comb begin
        cur_prod = 36'(shunt_sample) * $signed({21'h0, lnk.cal});
        next_current = 20'(cur_prod >>> 11); // see R12
        // Power step = 3.2 current steps: |I| * V(bus) scaled
        pwr_prod = 44'(next_current[19] ? -next_current : next_current)
            * 44'(bus_sample);
        next_power = 24'(pwr_prod >> 16); // see R7
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk.shunt_res <= '0;
            lnk.bus_res <= '0;
            lnk.power_res <= '0;
            current_res <= '0;
            lnk.conv_done <= 1'b0;
        end else begin
            lnk.conv_done <= sample_tick;
            if (sample_tick) begin
                lnk.shunt_res <= shunt_sample; // see R6
                // Bus never reported negative
                lnk.bus_res <= bus_sample[19] ? 20'h00000 : bus_sample;
                current_res <= next_current;
                lnk.power_res <= next_power;
            end
        end
    end

    // Energy step is 16 power steps, so add power >> 4
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            energy_acc <= '0;
        end else if (lnk.conv_done) begin
            energy_acc <= energy_acc + 40'(lnk.power_res >> 4); // see R8
        end
    end

    // ------------------------------------------------------------
    // Alert
    // ------------------------------------------------------------
    // Gross faults caught early at the quarter-period look
    // Gross means above twice a positive limit, never below it
    assign gross_fault = !shunt_upper_limit[15]
        && $signed({{2{shunt_sample[19]}}, shunt_sample[19 -: 16]})
        > $signed({1'b0, shunt_upper_limit, 1'b0});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk.alert <= 1'b0;
            alert_on_averaged_result <= 1'b0;
        end else if (quarter_tick && gross_fault) begin
            lnk.alert <= 1'b1; // see R9
        end else if (lnk.conv_done) begin // see R10
            lnk.alert <= // see R14
                ($signed(lnk.shunt_res[19 -: 16])
                    > $signed(shunt_upper_limit))
                || (lnk.bus_res[19 -: 16] > bus_upper_limit)
                || (lnk.power_res[23 -: 16] > power_limit);
            alert_on_averaged_result <= 1'b0;
        end
    end
endmodule : flas_device

// file: flas_props.sv
`timescale 1ns/1ns
module flas_props #(
    parameter int CONV_CYCLES = flas_pkg::CONV_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic lim_wr,
    input wire logic [1:0] lim_sel,
    input wire logic [15:0] lim_data,
    input wire logic [14:0] cal,
    input wire logic wide_range,
    input wire logic [19:0] shunt_res,
    input wire logic [19:0] bus_res,
    input wire logic [23:0] power_res,
    input wire logic conv_done,
    input wire logic alert
);
    logic [15:0] lim_s;
    logic [15:0] lim_b;
    logic [15:0] lim_p;
    logic [15:0] since;
    logic [15:0] cal_age;
    logic seen;
    logic over;
    // ------------------------------------------------------------
    // Mirror of limits and conversion spacing
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lim_s <= flas_pkg::SHUNT_LIMIT_RST;
            lim_b <= flas_pkg::BUS_LIMIT_RST;
            lim_p <= flas_pkg::POWER_LIMIT_RST;
        end else if (lim_wr) begin
            if (lim_sel == 2'h0) lim_s <= lim_data;
            if (lim_sel == 2'h1) lim_b <= lim_data;
            if (lim_sel == 2'h2) lim_p <= lim_data;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since <= 16'h0000;
            seen <= 1'b0;
        end else if (conv_done) begin
            since <= 16'h0000;
            seen <= 1'b1;
        end else begin
            since <= since + 16'h0001;
        end
    end
    // Saturates so a long idle run cannot wrap back to zero
    always_ff @(posedge aclk) begin
        if (!aresetn || cal != 15'h0000) cal_age <= 16'h0000;
        else if (cal_age != 16'hFFFF) cal_age <= cal_age + 16'h0001;
    end
    assign over = ($signed(shunt_res[19:4]) > $signed(lim_s))
        || (bus_res[19:4] > lim_b) || (power_res[23:8] > lim_p);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_conv_end;
        conv_done && !lim_wr;
    endsequence
    chk_done_spacing: assert property (
        seen && conv_done |-> since == 16'(CONV_CYCLES - 1))
        else $error("conversion spacing wrong");
    chk_done_bound: assert property (
        seen |-> since < 16'(CONV_CYCLES))
        else $error("conversion overdue");
    chk_alert_cmp: assert property (
        s_conv_end |=> alert == $past(over))
        else $error("alert disagrees with limits");
    chk_wr_pulse: assert property (
        lim_wr |=> !lim_wr)
        else $error("limit write not a pulse");
    chk_sel_range: assert property (
        lim_wr |-> lim_sel != 2'h3)
        else $error("limit select out of range");
    chk_cal_zero: assert property (
        cal_age > 16'(2 * CONV_CYCLES) |-> power_res == 24'h000000)
        else $error("power nonzero without calibration");
    chk_bus_sign: assert property (
        conv_done |-> !bus_res[19])
        else $error("bus result negative");
    chk_reset_vals: assert property (
        !$past(aresetn) |-> cal == flas_pkg::CAL_RST
            && wide_range == flas_pkg::WIDE_RANGE_RST && !alert)
        else $error("wrong values after reset");
endmodule : flas_props

// file: flas_tb_top.sv
`timescale 1ns/1ns
module flas_tb_top;
    localparam int CONV = 40;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [19:0] shunt_sample = 20'h00000;
    logic [19:0] bus_sample = 20'h00000;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic irq;
    logic [19:0] current_res;
    logic [39:0] energy_acc;
    logic alert_on_averaged_result;
    logic [31:0] rd;
    logic [1:0] rs;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    flas_if lnk ();
    flas_device #(.CONV_CYCLES(CONV)) flas_device_inst (.*);
    flas_host flas_host_inst (.*);
    flas_props #(.CONV_CYCLES(CONV)) flas_props_inst (
        .aclk(aclk), .aresetn(aresetn), .lim_wr(lnk.lim_wr),
        .lim_sel(lnk.lim_sel), .lim_data(lnk.lim_data), .cal(lnk.cal),
        .wide_range(lnk.wide_range), .shunt_res(lnk.shunt_res),
        .bus_res(lnk.bus_res), .power_res(lnk.power_res),
        .conv_done(lnk.conv_done), .alert(lnk.alert));

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    // Waits on conversions, then lets alert and irq settle
    task automatic settle(input int k);
        repeat (k) @(posedge lnk.conv_done);
        repeat (3) @(posedge aclk);
    endtask : settle
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        axi_rd(flas_pkg::A_SHUNT_LIM);
        check("shunt_lim", rd, 32'(flas_pkg::SHUNT_LIMIT_RST));
        axi_rd(flas_pkg::A_BUS_LIM);
        check("bus_lim", rd, 32'(flas_pkg::BUS_LIMIT_RST));
        axi_rd(flas_pkg::A_PWR_LIM);
        check("pwr_lim", rd, 32'(flas_pkg::POWER_LIMIT_RST));
        axi_rd(flas_pkg::A_CAL);
        check("cal", rd, 32'(flas_pkg::CAL_RST));
        check("irq", 32'(irq), 32'h00000000);
        check("avg_alrt", 32'(alert_on_averaged_result), 32'h0);
    endtask : t_defaults
    task automatic t_results();
        logic [39:0] e0;
        shunt_sample <= 20'hB4100;
        bus_sample <= 20'h3C000;
        settle(2);
        axi_rd(flas_pkg::A_SHUNT_RES);
        check("shunt_res", 32'(rd[19:0]), 32'h000B4100);
        axi_rd(flas_pkg::A_PWR_RES);
        check("pwr_nocal", rd, 32'h00000000);
        axi_wr(flas_pkg::A_CAL, 32'h00000800);
        shunt_sample <= 20'h4BF00;
        settle(2);
        axi_rd(flas_pkg::A_BUS_RES);
        check("bus_res", 32'(rd[19:0]), 32'h0003C000);
        axi_rd(flas_pkg::A_PWR_RES);
        check("pwr_res", 32'(rd[23:0]), 32'h0011CC40);
        check("cur_res", 32'(current_res), 32'h0004BF00);
        e0 = energy_acc;
        settle(1);
        check("energy", 32'(energy_acc - e0), 32'h00011CC4);
    endtask : t_results
    task automatic t_bus_alert();
        axi_wr(flas_pkg::A_ENABLE, 32'h00000008);
        axi_wr(flas_pkg::A_BUS_LIM, 32'h00004100);
        bus_sample <= 20'h41000;
        settle(2);
        check("bus_at_lim", 32'(lnk.alert), 32'h00000000);
        bus_sample <= 20'h41010;
        n = 0;
        while (!irq && n < 200) begin
            @(posedge aclk);
            n++;
        end
        // 1.5 periods plus the result, alert and irq registers
        check("bus_latency", 32'(n <= 63), 32'h00000001);
        axi_rd(flas_pkg::A_STATUS);
        check("st_alert", 32'(rd[3]), 32'h00000001);
        axi_wr(flas_pkg::A_ENABLE, 32'h00000000);
        repeat (2) @(posedge aclk);
        check("irq_masked", 32'(irq), 32'h00000000);
        axi_wr(flas_pkg::A_CLEAR, 32'h00000008);
        axi_rd(flas_pkg::A_STATUS);
        check("st_cleared", 32'(rd[3]), 32'h00000000);
        bus_sample <= 20'h3C000;
        settle(2);
        check("bus_ok", 32'(lnk.alert), 32'h00000000);
    endtask : t_bus_alert
    task automatic t_shunt_alert();
        axi_wr(flas_pkg::A_SHUNT_LIM, 32'h00007E90);
        shunt_sample <= 20'h7E900;
        settle(2);
        check("sh_at_lim", 32'(lnk.alert), 32'h00000000);
        shunt_sample <= 20'h7E910;
        settle(2);
        check("sh_over", 32'(lnk.alert), 32'h00000001);
        shunt_sample <= 20'hC0000;
        settle(2);
        check("sh_neg", 32'(lnk.alert), 32'h00000000);
        axi_wr(flas_pkg::A_SHUNT_LIM, 32'h00001000);
        settle(1);
        shunt_sample <= 20'h30000;
        // Past the quarter look, well before the next compare
        repeat (10) @(posedge aclk);
        check("sh_gross", 32'(lnk.alert), 32'h00000001);
        axi_wr(flas_pkg::A_SHUNT_LIM, 32'h00007E90);
        shunt_sample <= 20'h4BF00;
        settle(2);
    endtask : t_shunt_alert
    task automatic t_power_alert();
        axi_wr(flas_pkg::A_PWR_LIM, 32'h000011CC);
        settle(2);
        check("pw_at_lim", 32'(lnk.alert), 32'h00000000);
        axi_wr(flas_pkg::A_PWR_LIM, 32'h000011CB);
        settle(2);
        check("pw_over", 32'(lnk.alert), 32'h00000001);
    endtask : t_power_alert
    task automatic t_refused();
        axi_wr(8'h30, 32'h00001234);
        check("wr_resp", 32'(rs), 32'(flas_pkg::RESP_SLVERR));
        axi_rd(8'h30);
        check("rd_resp", 32'(rs), 32'(flas_pkg::RESP_SLVERR));
        check("rd_data", rd, 32'h00000000);
    endtask : t_refused
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_defaults();
        t_results();
        t_bus_alert();
        t_shunt_alert();
        t_power_alert();
        t_refused();
        // Limits must come back to defaults after a second reset
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_defaults();
        test_done();
    end
endmodule : flas_tb_top
